// *** include/svc_button_map.svh ***
`ifndef SVC_BUTTON_MAP_SVH
`define SVC_BUTTON_MAP_SVH

// ----------------------------------------
// clock and base tick
// ----------------------------------------
`define SVC_CLK_HZ 20000000
`define SVC_TICK_US 1000
`define SVC_TICK_CYCLES ((`SVC_CLK_HZ / 1000000) * `SVC_TICK_US)

// ----------------------------------------
// button hold times, in seconds, and as ms ticks
// ----------------------------------------
`define SVC_HOLD_RESTART_S 3
`define SVC_HOLD_COOL_S 10
`define SVC_HOLD_RESTART_MS (`SVC_HOLD_RESTART_S * 1000)
`define SVC_HOLD_COOL_MS (`SVC_HOLD_COOL_S * 1000)

// ----------------------------------------
// restart and acknowledge timing
// ----------------------------------------
`define SVC_RESUME_DELAY_MIN 3
`define SVC_RESUME_DELAY_MS (`SVC_RESUME_DELAY_MIN * 60 * 1000)
`define SVC_BEEP_DELAY_S 3
`define SVC_BEEP_DELAY_MS (`SVC_BEEP_DELAY_S * 1000)
`define SVC_BEEP_ON_MS 200
`define SVC_BEEP_OFF_MS 200
`define SVC_BEEP_COUNT 2'h3

// ----------------------------------------
// fixed operating values
// ----------------------------------------
`define SVC_AUTO_SET_TEMP_C 8'h19
`define SVC_COOL_COMP_RPS 8'h1e
`define SVC_COMP_IDLE_RPS 8'h00

`endif

// *** include/svc_button_pkg.sv ***
package svc_button_pkg;

	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_TEMP_AUTO = 2'h1,
		MODE_TEMP_COOL = 2'h2,
		MODE_REMOTE = 2'h3
	} run_mode_t;

	// gray along boot -> wait -> run -> stop
	typedef enum logic [1:0] {
		ST_BOOT = 2'h0,
		ST_WAIT = 2'h1,
		ST_RUN = 2'h3,
		ST_STOP = 2'h2
	} ctrl_state_t;

endpackage : svc_button_pkg

// *** design/ms_tick_div.sv ***
`timescale 1ns/1ps

module ms_tick_div #(
	parameter int unsigned DIV = 20000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// one-cycle enable every DIV clocks
	output logic tick
);
	localparam int unsigned W = (DIV > 1) ? $clog2(DIV) : 1;
	logic [W-1:0] cnt_reg;
	wire last = (cnt_reg == W'(DIV - 1));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			tick <= 1'b0;
		end else begin
			cnt_reg <= last ? '0 : cnt_reg + W'(1);
			tick <= last;
		end
	end
endmodule : ms_tick_div

// *** design/service_button_restart_ctrl.sv ***
// How it works
// - short press while stopped starts temporary auto operation
// - holding the button three seconds selects the restart setting action
// - holding the button ten seconds starts temporary cooling
// - temporary auto runs auto control with target fixed at 25 C
// - a further press during temporary operation stops the unit
// - remote commands stay accepted during temporary auto operation
// - restart enabled and temporary auto at power loss resumes temporary auto
// - temporary cooling fixes compressor at 30 rps and fan at low
// - temporary cooling is never resumed after power loss
// - restart resumes previous settings three minutes after power, no warning
// - restart setting is disabled when storage is factory blank
// - a restart setting change is acknowledged by three beeps
// - toggling from standby also starts operation
// - toggling while running stops, beeps three times after three seconds
// - while running, orange lamp means restart on, green means off
// - setting request ignored while remote timer operation is selected
// - after automatic restart the louver swing stays stopped
// - repeating the three second hold turns restart off, same beeps
// - restart disabled keeps unit stopped after power until a button or remote start
`timescale 1ns/1ps
`include "svc_button_map.svh"
module service_button_restart_ctrl
	import svc_button_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = `SVC_TICK_CYCLES,
	parameter int unsigned HOLD_RESTART_MS = `SVC_HOLD_RESTART_MS,
	parameter int unsigned HOLD_COOL_MS = `SVC_HOLD_COOL_MS,
	parameter int unsigned RESUME_DELAY_MS = `SVC_RESUME_DELAY_MS,
	parameter int unsigned BEEP_DELAY_MS = `SVC_BEEP_DELAY_MS,
	parameter int unsigned BEEP_ON_MS = `SVC_BEEP_ON_MS,
	parameter int unsigned BEEP_OFF_MS = `SVC_BEEP_OFF_MS
) (
	// clock and power-up reset
	input wire logic clk,
	input wire logic nrst,
	// service button pin, high while pressed
	input wire logic button_in,
	// remote receiver, same clock
	input wire logic remote_start,
	input wire logic remote_stop,
	input wire logic remote_timer_sel,
	input wire logic [7:0] remote_set_temp,
	input wire logic remote_swing,
	// non-volatile storage, read side then write side
	input wire logic nv_valid,
	input wire logic nv_restart_en_in,
	input wire logic [1:0] nv_mode_in,
	input wire logic [7:0] nv_temp_in,
	output logic nv_write_reg,
	output logic nv_restart_en_reg,
	output logic [1:0] nv_mode_reg,
	output logic [7:0] nv_temp_reg,
	// operating commands
	output logic run_reg,
	output logic [1:0] mode_reg,
	output logic [7:0] set_temp_reg,
	output logic comp_fixed_reg,
	output logic [7:0] comp_rps_reg,
	output logic fan_low_reg,
	output logic swing_reg,
	// indication
	output logic buzzer_reg,
	output logic lamp_orange_reg,
	output logic lamp_green_reg
);
	localparam int CW = 18;
	// ----------------------------------------
	// reset release and tick
	// ----------------------------------------
	logic rst_s1_reg, rst_n;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end
	logic tick;
	ms_tick_div #(.DIV(TICK_CYCLES)) u_tick (
		.clk(clk),
		.rst_n(rst_n),
		.tick(tick)
	);
	function automatic logic reached(input logic [CW-1:0] cnt, input int unsigned lim);
		reached = (cnt >= CW'(lim));
	endfunction : reached
	// ----------------------------------------
	// button synchroniser and hold timing
	// ----------------------------------------
	logic btn_s1_reg, btn_s2_reg, btn_prev_reg, cool_fired_reg;
	logic [CW-1:0] hold_ms_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			btn_s1_reg <= 1'b0;
			btn_s2_reg <= 1'b0;
			btn_prev_reg <= 1'b0;
		end else begin
			btn_s1_reg <= button_in;
			btn_s2_reg <= btn_s1_reg;
			btn_prev_reg <= btn_s2_reg;
		end
	end
	wire press = btn_s2_reg && !btn_prev_reg;
	wire release_ev = !btn_s2_reg && btn_prev_reg;
	// cooling fires while still held; the release that follows does nothing
	wire cool_evt = btn_prev_reg && !cool_fired_reg && reached(hold_ms_reg, HOLD_COOL_MS);
	wire short_evt = release_ev && !cool_fired_reg && !reached(hold_ms_reg, HOLD_RESTART_MS);
	wire toggle_req = release_ev && !cool_fired_reg && reached(hold_ms_reg, HOLD_RESTART_MS);
	wire toggle_ok = toggle_req && !remote_timer_sel;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_ms_reg <= '0;
			cool_fired_reg <= 1'b0;
		end else if (press) begin
			hold_ms_reg <= '0;
			cool_fired_reg <= 1'b0;
		end else begin
			if (tick && btn_prev_reg && !reached(hold_ms_reg, HOLD_COOL_MS))
				hold_ms_reg <= hold_ms_reg + CW'(1);
			if (cool_evt)
				cool_fired_reg <= 1'b1;
		end
	end
	// ----------------------------------------
	// operating state
	// ----------------------------------------
	ctrl_state_t st_reg, st_next;
	run_mode_t mode_next;
	logic restart_en_reg, restart_en_next, swing_next;
	logic [7:0] temp_next;
	logic [CW-1:0] wait_ms_reg;
	wire stopped = (st_reg == ST_STOP) || (st_reg == ST_WAIT);
	wire resume_evt = (st_reg == ST_WAIT) && tick && reached(wait_ms_reg, RESUME_DELAY_MS - 1);
	wire nv_resumable = nv_valid && nv_restart_en_in &&
		((nv_mode_in == MODE_TEMP_AUTO) || (nv_mode_in == MODE_REMOTE));
	wire beep_now = toggle_ok && stopped;
	wire beep_later = toggle_ok && (st_reg == ST_RUN);
	always_comb begin
		st_next = st_reg;
		mode_next = run_mode_t'(mode_reg);
		temp_next = set_temp_reg;
		swing_next = swing_reg;
		restart_en_next = toggle_ok ? !restart_en_reg : restart_en_reg;
		case (st_reg)
			ST_BOOT: begin
				restart_en_next = nv_valid && nv_restart_en_in;
				mode_next = nv_valid ? run_mode_t'(nv_mode_in) : MODE_OFF;
				temp_next = nv_temp_in;
				st_next = nv_resumable ? ST_WAIT : ST_STOP;
			end
			ST_WAIT, ST_STOP: begin
				if (cool_evt) begin
					st_next = ST_RUN;
					mode_next = MODE_TEMP_COOL;
				end else if (short_evt || toggle_ok) begin
					st_next = ST_RUN;
					mode_next = MODE_TEMP_AUTO;
					temp_next = `SVC_AUTO_SET_TEMP_C;
				end else if (remote_start) begin
					st_next = ST_RUN;
					mode_next = MODE_REMOTE;
					temp_next = remote_set_temp;
					swing_next = remote_swing;
				end else if (remote_stop) begin
					st_next = ST_STOP;
				end else if (resume_evt) begin
					st_next = ST_RUN;
					swing_next = 1'b0;
					temp_next = (mode_next == MODE_TEMP_AUTO) ? `SVC_AUTO_SET_TEMP_C : set_temp_reg;
				end
			end
			ST_RUN: begin
				if (cool_evt) begin
					mode_next = MODE_TEMP_COOL;
				end else if (short_evt || toggle_ok || remote_stop) begin
					st_next = ST_STOP;
				end else if (remote_start) begin
					mode_next = MODE_REMOTE;
					temp_next = remote_set_temp;
					swing_next = remote_swing;
				end
			end
			default: st_next = ST_STOP;
		endcase
	end
	wire run_next = (st_next == ST_RUN);
	wire cool_next = run_next && (mode_next == MODE_TEMP_COOL);
	// cooling is stored as stopped so it can never come back on its own
	wire [1:0] nv_mode_next = (st_next == ST_WAIT) ? nv_mode_reg :
		((run_next && !cool_next) ? mode_next : MODE_OFF);
	wire nv_change = (st_reg != ST_BOOT) && ((nv_mode_next != nv_mode_reg) ||
		(restart_en_next != nv_restart_en_reg) || (temp_next != nv_temp_reg));
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= ST_BOOT;
			mode_reg <= MODE_OFF;
			set_temp_reg <= `SVC_AUTO_SET_TEMP_C;
			swing_reg <= 1'b0;
			restart_en_reg <= 1'b0;
			run_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			mode_reg <= mode_next;
			set_temp_reg <= temp_next;
			swing_reg <= swing_next;
			restart_en_reg <= restart_en_next;
			run_reg <= run_next;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wait_ms_reg <= '0;
		else if (st_reg != ST_WAIT)
			wait_ms_reg <= '0;
		else if (tick)
			wait_ms_reg <= wait_ms_reg + CW'(1);
	end
	// ----------------------------------------
	// drive commands, lamps, storage
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comp_fixed_reg <= 1'b0;
			comp_rps_reg <= `SVC_COMP_IDLE_RPS;
			fan_low_reg <= 1'b0;
			lamp_orange_reg <= 1'b0;
			lamp_green_reg <= 1'b0;
		end else begin
			comp_fixed_reg <= cool_next;
			comp_rps_reg <= cool_next ? `SVC_COOL_COMP_RPS : `SVC_COMP_IDLE_RPS;
			fan_low_reg <= cool_next;
			lamp_orange_reg <= run_next && restart_en_next;
			lamp_green_reg <= run_next && !restart_en_next;
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nv_write_reg <= 1'b0;
			nv_restart_en_reg <= 1'b0;
			nv_mode_reg <= MODE_OFF;
			nv_temp_reg <= `SVC_AUTO_SET_TEMP_C;
		end else if (st_reg == ST_BOOT) begin
			// mirror storage first so power-up never writes defaults over it
			nv_write_reg <= 1'b0;
			nv_restart_en_reg <= nv_valid && nv_restart_en_in;
			nv_mode_reg <= nv_valid ? nv_mode_in : MODE_OFF;
			nv_temp_reg <= nv_temp_in;
		end else begin
			nv_write_reg <= nv_change;
			nv_restart_en_reg <= restart_en_next;
			nv_mode_reg <= nv_mode_next;
			nv_temp_reg <= temp_next;
		end
	end
	// ----------------------------------------
	// acknowledge beeps
	// ----------------------------------------
	logic beep_wait_reg;
	logic [1:0] beep_left_reg;
	logic [CW-1:0] beep_ms_reg;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			beep_wait_reg <= 1'b0;
			beep_left_reg <= 2'h0;
			beep_ms_reg <= '0;
			buzzer_reg <= 1'b0;
		end else if (beep_now) begin
			beep_left_reg <= `SVC_BEEP_COUNT;
			beep_wait_reg <= 1'b0;
			beep_ms_reg <= '0;
			buzzer_reg <= 1'b1;
		end else if (beep_later) begin
			beep_wait_reg <= 1'b1;
			beep_left_reg <= 2'h0;
			beep_ms_reg <= '0;
			buzzer_reg <= 1'b0;
		end else if (tick) begin
			if (beep_wait_reg) begin
				if (reached(beep_ms_reg, BEEP_DELAY_MS - 1)) begin
					beep_wait_reg <= 1'b0;
					beep_left_reg <= `SVC_BEEP_COUNT;
					beep_ms_reg <= '0;
					buzzer_reg <= 1'b1;
				end else
					beep_ms_reg <= beep_ms_reg + CW'(1);
			end else if (beep_left_reg != 2'h0) begin
				if (buzzer_reg && reached(beep_ms_reg, BEEP_ON_MS - 1)) begin
					buzzer_reg <= 1'b0;
					beep_ms_reg <= '0;
				end else if (!buzzer_reg && reached(beep_ms_reg, BEEP_OFF_MS - 1)) begin
					beep_left_reg <= beep_left_reg - 2'h1;
					buzzer_reg <= (beep_left_reg != 2'h1);
					beep_ms_reg <= '0;
				end else
					beep_ms_reg <= beep_ms_reg + CW'(1);
			end
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_toggle_running;
		toggle_ok && !cool_evt && st_reg == ST_RUN;
	endsequence
	sequence s_stopped_waiting;
		!run_reg && beep_wait_reg && !buzzer_reg;
	endsequence
	short_start_a: assert property (short_evt && stopped && !cool_evt |=>
		run_reg && mode_reg == MODE_TEMP_AUTO) else $error("short press did not start");
	cool_start_a: assert property (cool_evt |=> run_reg && comp_fixed_reg)
		else $error("ten second hold did not start cooling");
	auto_temp_a: assert property (run_reg && mode_reg == MODE_TEMP_AUTO |->
		set_temp_reg == `SVC_AUTO_SET_TEMP_C) else $error("temporary auto target wrong");
	press_stop_a: assert property (st_reg == ST_RUN && short_evt |=> !run_reg)
		else $error("press did not stop unit");
	cool_fixed_a: assert property (run_reg && mode_reg == MODE_TEMP_COOL |->
		comp_rps_reg == `SVC_COOL_COMP_RPS && fan_low_reg) else $error("cooling not fixed");
	no_cool_nv_a: assert property (nv_mode_reg != MODE_TEMP_COOL)
		else $error("cooling stored for restart");
	standby_beep_a: assert property (beep_now |=> run_reg && buzzer_reg &&
		beep_left_reg == `SVC_BEEP_COUNT) else $error("standby toggle not acknowledged");
	run_toggle_a: assert property (s_toggle_running |=> s_stopped_waiting [*2])
		else $error("running toggle did not stop and wait");
	lamp_state_a: assert property (lamp_orange_reg == (run_reg && restart_en_reg) &&
		lamp_green_reg == (run_reg && !restart_en_reg)) else $error("lamp wrong");
	timer_block_a: assert property (toggle_req && remote_timer_sel |=>
		$stable(restart_en_reg)) else $error("toggle taken during timer");
	resume_swing_a: assert property (resume_evt && !cool_evt && !short_evt &&
		!toggle_ok && !remote_start && !remote_stop |=> run_reg && !swing_reg && !buzzer_reg)
		else $error("resume wrong");
	wait_enabled_a: assert property (st_reg == ST_WAIT |-> restart_en_reg)
		else $error("waiting to resume while disabled");
endmodule : service_button_restart_ctrl

// *** test/svc_far_side.sv ***
`timescale 1ns/1ps

// ----------------------------------------
// operator, remote receiver and storage
// ----------------------------------------
module svc_far_side (
	// clock
	input wire logic clk,
	// operator and remote receiver
	output logic button_in,
	output logic remote_start,
	output logic remote_stop,
	output logic remote_timer_sel,
	output logic [7:0] remote_set_temp,
	output logic remote_swing,
	// storage write side
	input wire logic nv_write_reg,
	input wire logic nv_restart_en_reg,
	input wire logic [1:0] nv_mode_reg,
	input wire logic [7:0] nv_temp_reg,
	// storage read side
	output logic nv_valid,
	output logic nv_restart_en_in,
	output logic [1:0] nv_mode_in,
	output logic [7:0] nv_temp_in
);
	initial begin
		button_in = 1'b0;
		remote_start = 1'b0;
		remote_stop = 1'b0;
		remote_timer_sel = 1'b0;
		remote_set_temp = 8'h5a;
		remote_swing = 1'b0;
		nv_valid = 1'b0;
		nv_restart_en_in = 1'b0;
		nv_mode_in = 2'h0;
		nv_temp_in = 8'h00;
	end

	// no reset: contents outlive every power loss
	always @(posedge clk) begin
		if (nv_write_reg === 1'b1) begin
			nv_valid <= 1'b1;
			nv_restart_en_in <= nv_restart_en_reg;
			nv_mode_in <= nv_mode_reg;
			nv_temp_in <= nv_temp_reg;
		end
	end

	// button released means low, the pin's resting level
	task automatic press(input int n);
		@(posedge clk);
		button_in <= 1'b1;
		repeat (n) @(posedge clk);
		button_in <= 1'b0;
	endtask : press

	task automatic send_remote(input logic start, input logic [7:0] temp, input logic swing);
		@(posedge clk);
		remote_start <= start;
		remote_stop <= ~start;
		remote_set_temp <= temp;
		remote_swing <= swing;
		@(posedge clk);
		remote_start <= 1'b0;
		remote_stop <= 1'b0;
		// stale receiver data, so a late capture shows up
		remote_set_temp <= ~temp;
		remote_swing <= ~swing;
	endtask : send_remote

	task automatic set_timer(input logic v);
		@(posedge clk);
		remote_timer_sel <= v;
	endtask : set_timer
endmodule : svc_far_side

// *** test/service_button_restart_ctrl_tb.sv ***
`timescale 1ns/1ps

module service_button_restart_ctrl_tb;
	localparam int TICK = 4;
	localparam int HOLD_R = 3;
	localparam int HOLD_C = 10;
	localparam int RESUME = 20;
	localparam int SHORT_CYC = TICK;
	localparam int TOGGLE_CYC = TICK * (HOLD_R + HOLD_C) / 2;
	localparam int COOL_CYC = TICK * (HOLD_C + 4);
	localparam int RESUME_CYC = TICK * RESUME;
	// whole run needs about 2500 cycles
	localparam int LIMIT = 20000;

	typedef struct packed {
		int act;
		logic tsel;
		logic run;
		logic [1:0] mode;
		logic [7:0] temp;
		logic [7:0] rps;
		logic fan;
		logic orange;
		logic green;
		int beeps;
	} row_t;

	// act: 0 short press, 1 three second hold, 2 ten second hold, 3 remote start
	row_t rows [0:9] = '{
		'{0, 1'b0, 1'b1, 2'h1, 8'h19, 8'h00, 1'b0, 1'b0, 1'b1, 0},
		'{0, 1'b0, 1'b0, 2'h1, 8'h19, 8'h00, 1'b0, 1'b0, 1'b0, 0},
		'{1, 1'b1, 1'b0, 2'h1, 8'h19, 8'h00, 1'b0, 1'b0, 1'b0, 0},
		'{1, 1'b0, 1'b1, 2'h1, 8'h19, 8'h00, 1'b0, 1'b1, 1'b0, 3},
		'{3, 1'b0, 1'b1, 2'h3, 8'h16, 8'h00, 1'b0, 1'b1, 1'b0, 0},
		'{2, 1'b0, 1'b1, 2'h2, 8'h16, 8'h1e, 1'b1, 1'b1, 1'b0, 0},
		'{0, 1'b0, 1'b0, 2'h2, 8'h16, 8'h00, 1'b0, 1'b0, 1'b0, 0},
		'{0, 1'b0, 1'b1, 2'h1, 8'h19, 8'h00, 1'b0, 1'b1, 1'b0, 0},
		'{1, 1'b0, 1'b0, 2'h1, 8'h19, 8'h00, 1'b0, 1'b0, 1'b0, 3},
		'{1, 1'b0, 1'b1, 2'h1, 8'h19, 8'h00, 1'b0, 1'b1, 1'b0, 3}
	};

	logic clk;
	logic nrst;
	logic button_in, remote_start, remote_stop, remote_timer_sel, remote_swing;
	logic [7:0] remote_set_temp;
	logic nv_valid, nv_restart_en_in;
	logic [1:0] nv_mode_in;
	logic [7:0] nv_temp_in;
	logic nv_write_reg, nv_restart_en_reg;
	logic [1:0] nv_mode_reg, mode_reg;
	logic [7:0] nv_temp_reg, set_temp_reg, comp_rps_reg;
	logic run_reg, comp_fixed_reg, fan_low_reg, swing_reg;
	logic buzzer_reg, lamp_orange_reg, lamp_green_reg;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;

	service_button_restart_ctrl #(
		.TICK_CYCLES(TICK), .HOLD_RESTART_MS(HOLD_R), .HOLD_COOL_MS(HOLD_C),
		.RESUME_DELAY_MS(RESUME), .BEEP_DELAY_MS(3), .BEEP_ON_MS(2), .BEEP_OFF_MS(2)
	) u_service_button_restart_ctrl (
		.clk, .nrst, .button_in, .remote_start, .remote_stop, .remote_timer_sel,
		.remote_set_temp, .remote_swing, .nv_valid, .nv_restart_en_in, .nv_mode_in,
		.nv_temp_in, .nv_write_reg, .nv_restart_en_reg, .nv_mode_reg, .nv_temp_reg,
		.run_reg, .mode_reg, .set_temp_reg, .comp_fixed_reg, .comp_rps_reg,
		.fan_low_reg, .swing_reg, .buzzer_reg, .lamp_orange_reg, .lamp_green_reg
	);

	svc_far_side u_svc_far_side (
		.clk, .button_in, .remote_start, .remote_stop, .remote_timer_sel,
		.remote_set_temp, .remote_swing, .nv_write_reg, .nv_restart_en_reg,
		.nv_mode_reg, .nv_temp_reg, .nv_valid, .nv_restart_en_in, .nv_mode_in, .nv_temp_in
	);

	// ----------------------------------------
	// clock, timeout, report
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [7:0] act, input logic [7:0] exp);
		n_tests++;
		if (act !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
		end
	endtask : chk

	// counts buzzer bursts over n cycles
	task automatic watch(input int n, output int beeps);
		logic prev;
		beeps = 0;
		prev = buzzer_reg;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (buzzer_reg === 1'b1 && prev !== 1'b1) beeps++;
			prev = buzzer_reg;
		end
	endtask : watch

	task automatic power_cycle(input logic run, input logic [1:0] mode, input logic [7:0] temp);
		int nb;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (RESUME_CYC / 2) @(posedge clk);
		#1;
		chk(8'(run_reg), 8'h00);
		watch(RESUME_CYC, nb);
		chk(8'(run_reg), 8'(run));
		chk(8'(nb), 8'h00);
		chk(8'(swing_reg), 8'h00);
		if (run) begin
			chk(8'(mode_reg), 8'(mode));
			chk(set_temp_reg, temp);
		end
		$display("power cycle done");
	endtask : power_cycle

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int nb;
		nrst = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk(8'(run_reg), 8'h00);
		chk(set_temp_reg, 8'h19);
		chk(8'(nv_restart_en_reg), 8'h00);
		@(posedge clk);
		nrst <= 1'b1;
		repeat (6) @(posedge clk);
		for (int i = 0; i < 10; i++) begin
			u_svc_far_side.set_timer(rows[i].tsel);
			case (rows[i].act)
				0: u_svc_far_side.press(SHORT_CYC);
				1: u_svc_far_side.press(TOGGLE_CYC);
				2: u_svc_far_side.press(COOL_CYC);
				default: u_svc_far_side.send_remote(1'b1, 8'h16, 1'b0);
			endcase
			watch(140, nb);
			chk(8'(run_reg), 8'(rows[i].run));
			chk(8'(mode_reg), 8'(rows[i].mode));
			if (rows[i].mode !== 2'h2) chk(set_temp_reg, rows[i].temp);
			chk(comp_rps_reg, rows[i].rps);
			chk(8'(fan_low_reg), 8'(rows[i].fan));
			chk(8'(comp_fixed_reg), 8'(rows[i].fan));
			chk(8'(lamp_orange_reg), 8'(rows[i].orange));
			chk(8'(lamp_green_reg), 8'(rows[i].green));
			chk(8'(nb), 8'(rows[i].beeps));
			$display("row %0d done", i);
		end
		power_cycle(1'b1, 2'h1, 8'h19);
		u_svc_far_side.send_remote(1'b1, 8'h17, 1'b1);
		repeat (3) @(posedge clk);
		#1;
		chk(8'(swing_reg), 8'h01);
		power_cycle(1'b1, 2'h3, 8'h17);
		u_svc_far_side.press(COOL_CYC);
		watch(20, nb);
		chk(comp_rps_reg, 8'h1e);
		chk(8'(nv_mode_reg), 8'h00);
		power_cycle(1'b0, 2'h0, 8'h00);
		u_svc_far_side.press(TOGGLE_CYC);
		watch(140, nb);
		chk(8'(nb), 8'h03);
		chk(8'(run_reg), 8'h01);
		chk(8'(lamp_green_reg), 8'h01);
		power_cycle(1'b0, 2'h0, 8'h00);
		u_svc_far_side.send_remote(1'b1, 8'h18, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk(8'(run_reg), 8'h01);
		chk(set_temp_reg, 8'h18);
		u_svc_far_side.send_remote(1'b0, 8'h00, 1'b0);
		repeat (3) @(posedge clk);
		#1;
		chk(8'(run_reg), 8'h00);
		$display("remote start and stop done");
		summarize();
	end
endmodule : service_button_restart_ctrl_tb
